// ### hdl/two_wire_params.svh
// offsets, field positions, reset values and counts of the abort and slave timing block
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH

// register byte offsets
`define TW_OFS_FLAGS 8'h00
`define TW_OFS_SETUP 8'h04
`define TW_OFS_ACK 8'h08
`define TW_OFS_CTRL 8'h0c
`define TW_OFS_IRQ_ST 8'h10
`define TW_OFS_IRQ_MASK 8'h14

// abort cause bit positions
`define TW_BIT_SHORT_NAK 0
`define TW_BIT_LONG1_NAK 1
`define TW_BIT_LONG2_NAK 2
`define TW_BIT_DATA_NAK 3
`define TW_BIT_BCAST_NAK 4
`define TW_BIT_BCAST_READ 5
`define TW_BIT_SBYTE_ACK 7
`define TW_BIT_SBYTE_NORS 9
`define TW_BIT_TENBIT_RD 10

// control register fields
`define TW_CTRL_RESTART 0
`define TW_CTRL_STARTBYTE_OR_BROADCAST_SELECT 1
`define TW_CTRL_CHOICE 2

// interrupt status fields
`define TW_IRQ_ABORT 0
`define TW_IRQ_BCAST 1

// reset values
`define TW_RST_FLAGS 16'h0000
`define TW_RST_SETUP 8'h15
`define TW_RST_ACK 1'b1
`define TW_RST_RESTART 1'b1

// bus constants
`define TW_GCALL_ADDR 8'h00
`define TW_BYTE_BITS 4'h8

`endif

// ### hdl/two_wire_pkg.sv
// types shared by the abort and slave timing block
package two_wire_pkg;

  typedef enum logic [2:0] {
    PH_NONE, PH_SHORT_ADDR, PH_LONG_ADDR1, PH_LONG_ADDR2, PH_DATA, PH_BROADCAST, PH_STARTBYTE
  } mst_phase_e;

  typedef enum logic [1:0] {SL_IDLE, SL_ADDR, SL_ACK, SL_SKIP} slave_state_e;

  typedef struct packed {
    logic [2:0] sh;
    logic level;
  } pin_sync_s;

  typedef struct packed {
    logic [15:0] flags;
    logic [7:0] setup;
    logic ack_en;
    logic restart_allow;
    logic startbyte_or_broadcast_select_sel;
    logic choice_start;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic abort_pulse;
    logic d_wr;
    logic [7:0] d_addr;
    logic [31:0] rdata;
    logic scl_q;
    logic sda_q;
    slave_state_e sl;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic sda_oe;
  } ctrl_s;

endpackage

// ### hdl/pin_sync.sv
// three-stage pin synchroniser; level moves once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin and clean level
  input wire logic pin,
  output logic level
);

  two_wire_pkg::pin_sync_s st;
  two_wire_pkg::pin_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.sh = {st.sh[1:0], pin};
    if (st.sh[1] == st.sh[2]) begin
      next_st.level = st.sh[2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= {{3{RESET_LEVEL}}, RESET_LEVEL};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

// ### hdl/setup_timer.sv
// down counter that holds busy for a loaded number of clock periods
`timescale 1ns/1ns
module setup_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // load and status
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic busy
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_s;

  timer_s st;
  timer_s next_st;

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.cnt = value;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = (st.cnt != '0);

endmodule

// ### hdl/two_wire_abort_ctrl.sv
// abort cause capture, slave data setup stretch and broadcast call answer
// Contract
// - ten-bit read without restart sets bit 10
// - start byte without restart sets bit 9
// - bit 9 cleared with cause re-sets next cycle
// - acknowledged start byte sets bit 7
// - broadcast followed by read command sets bit 5
// - unacknowledged broadcast sets bit 4
// - unacknowledged data byte sets bit 3
// - unacknowledged second long address sets bit 2
// - unacknowledged first long address sets bit 1
// - unacknowledged short address sets bit 0
// - hold clock low setup count after data change
// - answer broadcast call only when enabled
`timescale 1ns/1ns
`include "two_wire_params.svh"
module two_wire_abort_ctrl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // transfer engine events
  input wire logic mst_req,
  input wire logic mst_req_read,
  input wire logic mst_req_tenbit,
  input wire logic mst_ack_strobe,
  input wire two_wire_pkg::mst_phase_e mst_phase,
  input wire logic mst_cmd_take,
  input wire logic mst_cmd_read,
  // transfer engine controls
  output logic repeated_start_allow,
  output logic startbyte_or_broadcast_select,
  output logic broadcast_versus_startbyte_choice,
  output logic tx_abort,
  output logic irq,
  // two-wire pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  two_wire_pkg::ctrl_s st;
  two_wire_pkg::ctrl_s next_st;
  logic scl_lvl;
  logic sda_lvl;
  logic timer_busy;
  logic timer_load;
  logic addr_ok;
  logic wr_flags;
  logic cause9;
  logic ack_seen;
  logic [15:0] setv;
  logic [15:0] clr;
  logic gcall_evt;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;
  logic [31:0] rmux;

  // ************************************************************
  // pin sampling and the clock stretch timer
  // ************************************************************
  pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(scl_in),
    .level(scl_lvl)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(sda_in),
    .level(sda_lvl)
  );

  setup_timer #(.W(8)) u_setup_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(timer_load),
    .value(st.setup),
    .busy(timer_busy)
  );

  // ************************************************************
  // register read view
  // ************************************************************
  always_comb begin
    rmux = 32'h0000_0000;
    case (haddr[7:0])
      `TW_OFS_FLAGS: rmux[15:0] = st.flags;
      `TW_OFS_SETUP: rmux[7:0] = st.setup;
      `TW_OFS_ACK: rmux[0] = st.ack_en;
      `TW_OFS_CTRL: rmux[2:0] = {st.choice_start, st.startbyte_or_broadcast_select_sel, st.restart_allow};
      `TW_OFS_IRQ_ST: rmux[1:0] = st.irq_st;
      `TW_OFS_IRQ_MASK: rmux[1:0] = st.irq_mask;
      default: rmux = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;
    addr_ok = hsel && htrans[1] && hready;
    wr_flags = st.d_wr && (st.d_addr == `TW_OFS_FLAGS);
    cause9 = !st.restart_allow && st.startbyte_or_broadcast_select_sel && st.choice_start;
    ack_seen = !sda_lvl;
    setv = 16'h0000;
    clr = wr_flags ? hwdata[15:0] : 16'h0000;
    gcall_evt = 1'b0;
    timer_load = 1'b0;
    bus_start = scl_lvl && st.scl_q && st.sda_q && !sda_lvl;
    bus_stop = scl_lvl && st.scl_q && !st.sda_q && sda_lvl;
    scl_rise = scl_lvl && !st.scl_q;
    scl_fall = !scl_lvl && st.scl_q;

    // bus address phase: latch, and answer reads from flops
    next_st.d_wr = addr_ok && hwrite;
    next_st.d_addr = haddr[7:0];
    next_st.rdata = (addr_ok && !hwrite) ? rmux : 32'h0000_0000;

    // bus data phase writes
    if (st.d_wr) begin
      case (st.d_addr)
        `TW_OFS_SETUP: next_st.setup = hwdata[7:0];
        `TW_OFS_ACK: next_st.ack_en = hwdata[0];
        `TW_OFS_CTRL: begin
          next_st.restart_allow = hwdata[`TW_CTRL_RESTART];
          next_st.startbyte_or_broadcast_select_sel = hwdata[`TW_CTRL_STARTBYTE_OR_BROADCAST_SELECT];
          next_st.choice_start = hwdata[`TW_CTRL_CHOICE];
        end
        `TW_OFS_IRQ_MASK: next_st.irq_mask = hwdata[1:0];
        default: ;
      endcase
    end

    // abort causes seen at request time
    if (mst_req && mst_req_read && mst_req_tenbit && !st.restart_allow) begin
      setv[`TW_BIT_TENBIT_RD] = 1'b1;
    end
    setv[`TW_BIT_SBYTE_NORS] = cause9;
    if (mst_cmd_take && mst_cmd_read && st.startbyte_or_broadcast_select_sel && !st.choice_start) begin
      setv[`TW_BIT_BCAST_READ] = 1'b1;
    end

    // abort causes seen at the acknowledge slot
    if (mst_ack_strobe) begin
      case (mst_phase)
        two_wire_pkg::PH_STARTBYTE: setv[`TW_BIT_SBYTE_ACK] = ack_seen;
        two_wire_pkg::PH_BROADCAST: setv[`TW_BIT_BCAST_NAK] = !ack_seen;
        two_wire_pkg::PH_DATA: setv[`TW_BIT_DATA_NAK] = !ack_seen;
        two_wire_pkg::PH_LONG_ADDR2: setv[`TW_BIT_LONG2_NAK] = !ack_seen;
        two_wire_pkg::PH_LONG_ADDR1: setv[`TW_BIT_LONG1_NAK] = !ack_seen;
        two_wire_pkg::PH_SHORT_ADDR: setv[`TW_BIT_SHORT_NAK] = !ack_seen;
        default: ;
      endcase
    end

    // sticky; a set beats a clear, except bit 9 where the clear wins
    // for one cycle so that a lasting cause shows as a re-assertion
    clr[`TW_BIT_SBYTE_NORS] = clr[`TW_BIT_SBYTE_NORS] & 1'b1;
    setv[`TW_BIT_SBYTE_NORS] = setv[`TW_BIT_SBYTE_NORS] & !clr[`TW_BIT_SBYTE_NORS];
    next_st.flags = (st.flags & ~clr) | setv;
    next_st.abort_pulse = |(setv & ~st.flags);

    // slave side: only the broadcast address byte is answered here
    case (st.sl)
      two_wire_pkg::SL_IDLE: ;
      two_wire_pkg::SL_ADDR: begin
        if (scl_rise) begin
          next_st.shreg = {st.shreg[6:0], sda_lvl};
          next_st.bits = st.bits + 4'h1;
        end
        if (scl_fall && st.bits == `TW_BYTE_BITS) begin
          if (st.shreg == `TW_GCALL_ADDR && st.ack_en) begin
            next_st.sda_oe = 1'b1;
            timer_load = 1'b1;
            gcall_evt = 1'b1;
            next_st.sl = two_wire_pkg::SL_ACK;
          end else begin
            next_st.sl = two_wire_pkg::SL_SKIP;
          end
        end
      end
      two_wire_pkg::SL_ACK: begin
        if (scl_fall) begin
          next_st.sda_oe = 1'b0;
          next_st.sl = two_wire_pkg::SL_SKIP;
        end
      end
      two_wire_pkg::SL_SKIP: ;
      default: next_st.sl = two_wire_pkg::SL_IDLE;
    endcase
    if (bus_start) begin
      next_st.sl = two_wire_pkg::SL_ADDR;
      next_st.bits = 4'h0;
      next_st.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_st.sl = two_wire_pkg::SL_IDLE;
      next_st.sda_oe = 1'b0;
    end
    next_st.scl_q = scl_lvl;
    next_st.sda_q = sda_lvl;

    // interrupt status clears on read; a new event in that cycle wins
    if (addr_ok && !hwrite && haddr[7:0] == `TW_OFS_IRQ_ST) begin
      next_st.irq_st = 2'h0;
    end
    if (next_st.abort_pulse) begin
      next_st.irq_st[`TW_IRQ_ABORT] = 1'b1;
    end
    if (gcall_evt) begin
      next_st.irq_st[`TW_IRQ_BCAST] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.flags <= `TW_RST_FLAGS;
      st.setup <= `TW_RST_SETUP;
      st.ack_en <= `TW_RST_ACK;
      st.restart_allow <= `TW_RST_RESTART;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.sl <= two_wire_pkg::SL_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign repeated_start_allow = st.restart_allow;
  assign startbyte_or_broadcast_select = st.startbyte_or_broadcast_select_sel;
  assign broadcast_versus_startbyte_choice = st.choice_start;
  assign tx_abort = st.abort_pulse;
  assign irq = |(st.irq_st & st.irq_mask);
  // open drain: the pins are only ever pulled low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = timer_busy;
  assign sda_oe = st.sda_oe;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TENBIT_READ_NORESTART: assert property (
    mst_req && mst_req_read && mst_req_tenbit && !st.restart_allow
      |=> st.flags[`TW_BIT_TENBIT_RD] && (tx_abort || $past(st.flags[`TW_BIT_TENBIT_RD]))
  ) else $error("ten-bit read without restart not flagged");

  AST_STARTBYTE_NORESTART: assert property (
    cause9 && !(wr_flags && hwdata[`TW_BIT_SBYTE_NORS]) |=> st.flags[`TW_BIT_SBYTE_NORS]
  ) else $error("start byte without restart not flagged");

  AST_BIT9_REASSERT: assert property (
    (wr_flags && hwdata[`TW_BIT_SBYTE_NORS] && cause9) ##1
      !(wr_flags && hwdata[`TW_BIT_SBYTE_NORS]) && cause9
      |-> !st.flags[`TW_BIT_SBYTE_NORS] ##1 st.flags[`TW_BIT_SBYTE_NORS]
  ) else $error("bit 9 did not drop for exactly one cycle");

  AST_STARTBYTE_ACKED: assert property (
    mst_ack_strobe && mst_phase == two_wire_pkg::PH_STARTBYTE && !sda_lvl
      |=> st.flags[`TW_BIT_SBYTE_ACK]
  ) else $error("acknowledged start byte not flagged");

  AST_BCAST_READ: assert property (
    mst_cmd_take && mst_cmd_read && st.startbyte_or_broadcast_select_sel && !st.choice_start
      |=> st.flags[`TW_BIT_BCAST_READ]
  ) else $error("read after broadcast not flagged");

  AST_BCAST_NAK: assert property (
    mst_ack_strobe && mst_phase == two_wire_pkg::PH_BROADCAST && sda_lvl
      |=> st.flags[`TW_BIT_BCAST_NAK]
  ) else $error("unanswered broadcast not flagged");

  AST_DATA_NAK: assert property (
    mst_ack_strobe && mst_phase == two_wire_pkg::PH_DATA
      && !(wr_flags && hwdata[`TW_BIT_DATA_NAK])
      |=> st.flags[`TW_BIT_DATA_NAK] == ($past(sda_lvl) || $past(st.flags[`TW_BIT_DATA_NAK]))
  ) else $error("data byte acknowledge misjudged");

  AST_LONG2_NAK: assert property (
    mst_ack_strobe && mst_phase == two_wire_pkg::PH_LONG_ADDR2 && sda_lvl
      |=> st.flags[`TW_BIT_LONG2_NAK]
  ) else $error("second long address refusal not flagged");

  AST_LONG1_NAK: assert property (
    mst_ack_strobe && mst_phase == two_wire_pkg::PH_LONG_ADDR1 && sda_lvl
      |=> st.flags[`TW_BIT_LONG1_NAK]
  ) else $error("first long address refusal not flagged");

  AST_SHORT_NAK: assert property (
    mst_ack_strobe && mst_phase == two_wire_pkg::PH_SHORT_ADDR && sda_lvl
      |=> st.flags[`TW_BIT_SHORT_NAK]
  ) else $error("short address refusal not flagged");

  AST_SETUP_HOLD: assert property (
    $rose(st.sda_oe) && $past(st.setup) == 8'h02 |-> scl_oe [*2] ##1 !scl_oe
  ) else $error("clock hold after data change has wrong length");

  AST_BCAST_ANSWER_GATED: assert property (
    $rose(st.sda_oe) |-> $past(st.ack_en) && $past(st.shreg) == `TW_GCALL_ADDR
  ) else $error("broadcast answered while disabled");

  AST_FLAG_STICKY: assert property (
    st.flags[`TW_BIT_SHORT_NAK] && !(wr_flags && hwdata[`TW_BIT_SHORT_NAK])
      |=> st.flags[`TW_BIT_SHORT_NAK]
  ) else $error("abort cause bit lost without a clear");

endmodule

// ### tb/two_wire_remote.sv
// remote bus party: general-call master and acknowledging slave
`timescale 1ns/1ns
module two_wire_remote (
  // resolved pins
  input wire logic scl,
  input wire logic sda,
  // open-drain pulls, high pulls the line low
  output logic scl_pull,
  output logic sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // slave answering an acknowledge slot: low acknowledges
  task automatic hold_sda(input logic low);
    // step off the sampling edge of the block's clock
    #25 sda_pull = low;
  endtask

  // one master frame of a single address byte, msb first, then stop
  task automatic frame(input logic [7:0] b, output logic acked);
    // pin changes stay a quarter period away from the block's clock edges
    #25 sda_pull = 1'b1;
    #400 scl_pull = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #200 sda_pull = ~b[i];
      #200 scl_pull = 1'b0;
      #400 scl_pull = 1'b1;
    end
    #200 sda_pull = 1'b0;
    // long low phase so the block's stretch surely starts before we let go
    #600 scl_pull = 1'b0;
    wait (scl === 1'b1);
    #225 acked = ~sda;
    #200 scl_pull = 1'b1;
    #200 sda_pull = 1'b1;
    #200 scl_pull = 1'b0;
    #400 sda_pull = 1'b0;
    #800;
  endtask
endmodule

// ### tb/tb_two_wire_abort_ctrl.sv
// self-checking bench of abort causes, setup stretch and broadcast answer
`timescale 1ns/1ns
`include "two_wire_params.svh"
module tb_two_wire_abort_ctrl;
  typedef struct {
    string what;
    logic [31:0] v;
  } note_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] ev = 6'h0;
  two_wire_pkg::mst_phase_e ph = two_wire_pkg::PH_NONE;
  logic hreadyout, hresp, rs_allow, sel, choice, tx_abort, irq, scl_oe, sda_oe;
  logic scl_pull, sda_pull, acked;
  logic [31:0] hrdata;
  wire logic scl = !(scl_oe | scl_pull);
  wire logic sda = !(sda_oe | sda_pull);
  note_s q[$];
  int n_fail = 0;
  int n_compared = 0;
  int n_pulse = 0;
  int hold = 0;
  integer seed = 32'h6e7c;
  logic rd_dp = 1'b0;

  always #50 hclk = ~hclk;

  two_wire_abort_ctrl i_two_wire_abort_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .mst_req(ev[5]), .mst_req_read(ev[4]), .mst_req_tenbit(ev[3]),
    .mst_ack_strobe(ev[2]), .mst_phase(ph), .mst_cmd_take(ev[1]), .mst_cmd_read(ev[0]),
    .repeated_start_allow(rs_allow), .startbyte_or_broadcast_select(sel),
    .broadcast_versus_startbyte_choice(choice), .tx_abort(tx_abort), .irq(irq),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe)
  );

  two_wire_remote i_two_wire_remote (
    .scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull)
  );

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    q.push_back('{what, exp});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic engine(input logic [5:0] v, input two_wire_pkg::mst_phase_e p);
    ev <= v;
    ph <= p;
    @(posedge hclk);
    ev <= 6'h0;
    repeat (2) @(posedge hclk);
  endtask

  task automatic frame(input logic [7:0] b, input logic exp);
    i_two_wire_remote.frame(b, acked);
    check("gcall ack", {31'h0, exp}, {31'h0, acked});
    @(posedge hclk);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ************************************************************
  // monitor: read data and clock stretch lengths against notes
  // ************************************************************
  always @(posedge hclk) begin
    note_s nt;
    if (rd_dp && hreadyout) begin
      nt = q.pop_front();
      check(nt.what, nt.v, hrdata);
      check("hresp", 32'h0, {31'h0, hresp});
    end
    rd_dp <= hsel && htrans[1] && hreadyout && !hwrite;
    if (tx_abort === 1'b1) n_pulse++;
    if (scl_oe === 1'b1) hold++;
    else if (hold != 0) begin
      nt = q.pop_front();
      check(nt.what, nt.v, 32'(hold));
      hold = 0;
    end
  end

  initial begin
    #3000000;
    n_fail++;
    give_verdict();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [7:0] s;
    int base;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("flags", `TW_OFS_FLAGS, 32'h0);
    rd("setup", `TW_OFS_SETUP, 32'h15);
    rd("bcast ack", `TW_OFS_ACK, 32'h1);
    rd("ctrl", `TW_OFS_CTRL, 32'h1);
    rd("irq mask", `TW_OFS_IRQ_MASK, 32'h0);
    bus(1'b1, 8'h18, 32'hffffffff);
    rd("unmapped", 8'h18, 32'h0);
    q.push_back('{"stretch", 32'h15});
    frame(`TW_GCALL_ADDR, 1'b1);
    rd("irq status", `TW_OFS_IRQ_ST, 32'h2);
    frame(8'h5a, 1'b0);
    bus(1'b1, `TW_OFS_ACK, 32'h0);
    frame(`TW_GCALL_ADDR, 1'b0);
    bus(1'b1, `TW_OFS_ACK, 32'h1);
    // at 100 ns a period, three periods cover the slow-mode minimum
    s = 8'(($random(seed) & 32'h1f) + 3);
    bus(1'b1, `TW_OFS_SETUP, {24'h0, s});
    rd("setup", `TW_OFS_SETUP, {24'h0, s});
    q.push_back('{"stretch", {24'h0, s}});
    frame(`TW_GCALL_ADDR, 1'b1);
    bus(1'b1, `TW_OFS_SETUP, 32'h0);
    frame(`TW_GCALL_ADDR, 1'b1);
    // two periods still meet the fast-mode minimum
    bus(1'b1, `TW_OFS_SETUP, 32'h2);
    q.push_back('{"stretch", 32'h2});
    frame(`TW_GCALL_ADDR, 1'b1);
    rd("irq status", `TW_OFS_IRQ_ST, 32'h2);
    // acknowledge slots; the first one runs with the interrupt masked
    for (int i = 0; i < 6; i++) begin
      i_two_wire_remote.hold_sda(i == 5);
      repeat (6) @(posedge hclk);
      base = n_pulse;
      engine(6'h04, two_wire_pkg::mst_phase_e'(3'(i + 1)));
      check("abort event", 32'h1, 32'(n_pulse - base));
      check("irq", {31'h0, i != 0}, {31'h0, irq});
      if (i == 0) bus(1'b1, `TW_OFS_IRQ_MASK, 32'h3);
      rd("flags", `TW_OFS_FLAGS, 32'h1 << ((i == 5) ? 7 : i));
      rd("irq status", `TW_OFS_IRQ_ST, 32'h1);
      bus(1'b1, `TW_OFS_FLAGS, 32'hffff);
      rd("flags cleared", `TW_OFS_FLAGS, 32'h0);
    end
    i_two_wire_remote.hold_sda(1'b0);
    @(posedge hclk);
    // no restart, broadcast selected: ten-bit read and read after broadcast both abort
    bus(1'b1, `TW_OFS_CTRL, 32'h2);
    engine(6'h38, two_wire_pkg::PH_NONE);
    engine(6'h03, two_wire_pkg::PH_BROADCAST);
    check("ctrl pins", 32'h2, {29'h0, choice, sel, rs_allow});
    rd("flags", `TW_OFS_FLAGS, 32'h0420);
    bus(1'b1, `TW_OFS_CTRL, 32'h6);
    repeat (2) @(posedge hclk);
    // clearing while the cause stays only drops bit 9 for a cycle
    bus(1'b1, `TW_OFS_FLAGS, 32'hffff);
    rd("flags dropped", `TW_OFS_FLAGS, 32'h0);
    rd("flags", `TW_OFS_FLAGS, 32'h0200);
    bus(1'b1, `TW_OFS_CTRL, 32'h7);
    bus(1'b1, `TW_OFS_FLAGS, 32'hffff);
    rd("flags", `TW_OFS_FLAGS, 32'h0);
    check("ctrl pins", 32'h7, {29'h0, choice, sel, rs_allow});
    rd("irq status", `TW_OFS_IRQ_ST, 32'h1);
    repeat (4) @(posedge hclk);
    give_verdict();
  end
endmodule
